// >>> src/tws_pkg.sv
/*
   Shared constants of the two-wire slave receiver: register offsets on the
   APB word map, bit positions of the control and own address fields, reset values,
   status codes and the one-hot state codes.
   Assumes a 32-bit APB with byte addresses carried on an 8-bit paddr.
*/
package tws_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_BUS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_OWN_ADDRESS = 8'h04;
   localparam logic [7:0] OFS_BUS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_BUS_DATA    = 8'h0C;

   // bus_control bit positions
   localparam int BIT_IRQ_FLAG       = 7;
   localparam int BIT_ACK_ENABLE     = 6;
   localparam int BIT_START_REQUEST  = 5;
   localparam int BIT_STOP_REQUEST   = 4;
   localparam int BIT_WRITE_COLL     = 3;
   localparam int BIT_IFACE_ENABLE   = 2;
   localparam int BIT_IRQ_ENABLE     = 0;

   // own_slave_address: address in [7:1], general call enable in [0]
   localparam int BIT_GC_ENABLE      = 0;

   // reset values
   localparam logic [7:0] RST_OWN_ADDRESS = 8'hFE;
   localparam logic [7:0] RST_BUS_DATA    = 8'hFF;
   localparam logic [1:0] RST_PRESCALER   = 2'h0;

   // general call address, seven bits
   localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

   // status codes, prescaler bits masked to zero
   localparam logic [7:0] ST_OWN_WRITE_ACK    = 8'h60;
   localparam logic [7:0] ST_ARB_OWN_WRITE    = 8'h68;
   localparam logic [7:0] ST_GCALL_ACK        = 8'h70;
   localparam logic [7:0] ST_ARB_GCALL        = 8'h78;
   localparam logic [7:0] ST_OWN_DATA_ACK     = 8'h80;
   localparam logic [7:0] ST_OWN_DATA_NACK    = 8'h88;
   localparam logic [7:0] ST_GC_DATA_ACK      = 8'h90;
   localparam logic [7:0] ST_GC_DATA_NACK     = 8'h98;
   localparam logic [7:0] ST_STOP_ADDRESSED   = 8'hA0;
   localparam logic [7:0] ST_NO_INFO          = 8'hF8;

   // bits in one address or data byte
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [6:0] {
      ST_IDLE     = 7'h01,
      ST_ADDR     = 7'h02,
      ST_ADDR_ACK = 7'h04,
      ST_WAIT     = 7'h08,
      ST_DATA     = 7'h10,
      ST_DATA_ACK = 7'h20,
      ST_IGNORE   = 7'h40
   } tws_state_type;

endpackage : tws_pkg

// >>> src/tws_slave_receiver.sv
/*
   Two-wire slave receiver with its APB register file: own address and
   general call recognition, per-byte acknowledge, status codes, clock
   stretching while software serves the flag, and wake-up from sleep.
   Assumes scl_i and sda_i come from the pins, asynchronous to pclk and at
   least eight pclk periods per bus clock; the pad resolves open drain from
   the enables (output value is always low).
*/
// Local design decisions: the APB slave port and the placing of the registers.
// Operation
// - match address against upper seven own bits
// - own bit zero enables general call answer
// - direction zero receives, one means transmitter
// - own address write sets flag and status
// - lost arbitration then addressed gives 0x68/0x78
// - ack enable cleared gives nack next byte
// - ack enable zero ignores address, keeps monitoring
// - sleep matching still works, wakes the part
// - after wake match hold clock until cleared
// - data register unreliable after sleep wake
// - writing one clears flag and continues
// - status 0x60 own address, 0x70 general call
// - next byte acked per ack enable
// - own data status 0x80 acked, 0x88 not
// - general call data 0x90 acked, 0x98 not
// - after nack status return to not addressed
// - general call recognised only when enabled
// - start request issues start when bus free; code does this only if it is set as the flag clears after 0x88/0x98
`timescale 1ns/1ps
module tws_slave_receiver (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic        sleep_active,
   input  wire logic        arb_lost,
   output logic             wake_req,
   output logic             start_issue
);

   typedef struct packed {
      tws_pkg::tws_state_type state;
      logic [3:0]  bit_cnt;
      logic [7:0]  shift;
      logic        gc_mode;
      logic        acked;
      logic        irq_flag;
      logic        ack_enable;
      logic        start_request;
      logic        stop_request;
      logic        write_collision;
      logic        iface_enable;
      logic        irq_enable;
      logic [7:0]  own_addr;
      logic [7:0]  status;
      logic [1:0]  prescaler;
      logic [7:0]  data;
      logic        scl_s1;
      logic        scl_s2;
      logic        scl_s3;
      logic        sda_s1;
      logic        sda_s2;
      logic        sda_s3;
      logic        scl_oe;
      logic        sda_oe;
      logic        busy;
      logic        start_pend;
      logic        start_issue;
      logic        wake;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } tws_regs_type;

   tws_regs_type st_reg;
   tws_regs_type st_next;

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic addr_own;
   logic addr_gc;
   logic apb_setup;
   logic apb_write;
   logic addressed;

   assign prdata      = st_reg.prdata;
   assign pready      = st_reg.pready;
   assign pslverr     = st_reg.pslverr;
   assign scl_o       = 1'b0;
   assign sda_o       = 1'b0;
   assign scl_oe      = st_reg.scl_oe;
   assign sda_oe      = st_reg.sda_oe;
   assign wake_req    = st_reg.wake;
   assign start_issue = st_reg.start_issue;

   always_comb begin
      st_next   = st_reg;
      // only the second and third stages are looked at
      scl_rise   = st_reg.scl_s2 & ~st_reg.scl_s3;
      scl_fall   = ~st_reg.scl_s2 & st_reg.scl_s3;
      start_cond = st_reg.scl_s2 & st_reg.scl_s3 & st_reg.sda_s3 & ~st_reg.sda_s2;
      stop_cond  = st_reg.scl_s2 & st_reg.scl_s3 & ~st_reg.sda_s3 & st_reg.sda_s2;
      addr_own   = (st_reg.shift[7:1] == st_reg.own_addr[7:1]);
      addr_gc    = (st_reg.shift[7:1] == tws_pkg::GENERAL_CALL_ADDR)
                   & st_reg.own_addr[tws_pkg::BIT_GC_ENABLE];
      addressed  = (st_reg.state == tws_pkg::ST_DATA) | (st_reg.state == tws_pkg::ST_DATA_ACK);
      apb_setup  = psel & ~penable;
      apb_write  = psel & penable & pwrite & st_reg.pready & ~st_reg.pslverr;

      st_next.scl_s1      = scl_i;
      st_next.scl_s2      = st_reg.scl_s1;
      st_next.scl_s3      = st_reg.scl_s2;
      st_next.sda_s1      = sda_i;
      st_next.sda_s2      = st_reg.sda_s1;
      st_next.sda_s3      = st_reg.sda_s2;
      st_next.start_issue = 1'b0;
      if (start_cond) begin
         st_next.busy = 1'b1;
      end else if (stop_cond) begin
         st_next.busy = 1'b0;
      end

      // apb: read data and answer prepared in the setup cycle, so the
      // access cycle always completes with no wait state
      st_next.pready  = apb_setup;
      st_next.pslverr = 1'b0;
      st_next.prdata  = 32'h0000_0000;
      if (apb_setup && !pwrite) begin
         if (paddr == tws_pkg::OFS_BUS_CONTROL) begin
            st_next.prdata[7:0] = {st_reg.irq_flag, st_reg.ack_enable, st_reg.start_request,
                                   st_reg.stop_request, st_reg.write_collision,
                                   st_reg.iface_enable, 1'b0, st_reg.irq_enable};
         end else if (paddr == tws_pkg::OFS_OWN_ADDRESS) begin
            st_next.prdata[7:0] = st_reg.own_addr;
         end else if (paddr == tws_pkg::OFS_BUS_STATUS) begin
            // prescaler bits are not masked here; software masks them
            st_next.prdata[7:0] = {st_reg.status[7:3], 1'b0, st_reg.prescaler};
         end else if (paddr == tws_pkg::OFS_BUS_DATA) begin
            st_next.prdata[7:0] = st_reg.data;
         end else begin
            st_next.pslverr = 1'b1;
         end
      end else if (apb_setup) begin
         if (paddr != tws_pkg::OFS_BUS_CONTROL && paddr != tws_pkg::OFS_OWN_ADDRESS &&
             paddr != tws_pkg::OFS_BUS_STATUS && paddr != tws_pkg::OFS_BUS_DATA) begin
            st_next.pslverr = 1'b1;
         end
      end
      if (apb_write) begin
         if (paddr == tws_pkg::OFS_BUS_CONTROL) begin
            if (pwdata[tws_pkg::BIT_IRQ_FLAG]) begin
               st_next.irq_flag = 1'b0;
            end
            st_next.ack_enable    = pwdata[tws_pkg::BIT_ACK_ENABLE];
            st_next.start_request = pwdata[tws_pkg::BIT_START_REQUEST];
            st_next.stop_request  = pwdata[tws_pkg::BIT_STOP_REQUEST];
            st_next.iface_enable  = pwdata[tws_pkg::BIT_IFACE_ENABLE];
            st_next.irq_enable    = pwdata[tws_pkg::BIT_IRQ_ENABLE];
         end else if (paddr == tws_pkg::OFS_OWN_ADDRESS) begin
            st_next.own_addr = pwdata[7:0];
         end else if (paddr == tws_pkg::OFS_BUS_STATUS) begin
            st_next.prescaler = pwdata[1:0];
         end else if (paddr == tws_pkg::OFS_BUS_DATA) begin
            // an APB write may only change the data register while the flag is up
            if (st_reg.irq_flag) begin
               st_next.data            = pwdata[7:0];
               st_next.write_collision = 1'b0;
            end else begin
               st_next.write_collision = 1'b1;
            end
         end
      end

      // bus engine; hardware sets of the flag come after the clear above
      case (st_reg.state)
         tws_pkg::ST_IDLE, tws_pkg::ST_IGNORE: begin
            st_next.sda_oe = 1'b0;
            st_next.scl_oe = 1'b0;
         end
         tws_pkg::ST_ADDR: begin
            if (scl_rise) begin
               st_next.shift   = {st_reg.shift[6:0], st_reg.sda_s2};
               st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            end else if (scl_fall && st_reg.bit_cnt == tws_pkg::BITS_PER_BYTE) begin
               // a read request would belong to the transmitter, not built here
               if ((addr_own || addr_gc) && st_reg.ack_enable && !st_reg.shift[0]) begin
                  st_next.state   = tws_pkg::ST_ADDR_ACK;
                  st_next.sda_oe  = 1'b1;
                  st_next.gc_mode = addr_gc & ~addr_own;
               end else begin
                  st_next.state = tws_pkg::ST_IGNORE;
               end
            end
         end
         tws_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
               st_next.sda_oe   = 1'b0;
               st_next.scl_oe   = 1'b1;
               st_next.irq_flag = 1'b1;
               st_next.state    = tws_pkg::ST_WAIT;
               if (arb_lost) begin
                  st_next.status = st_reg.gc_mode ? tws_pkg::ST_ARB_GCALL
                                                  : tws_pkg::ST_ARB_OWN_WRITE;
               end else begin
                  st_next.status = st_reg.gc_mode ? tws_pkg::ST_GCALL_ACK
                                                  : tws_pkg::ST_OWN_WRITE_ACK;
               end
               if (sleep_active) begin
                  st_next.wake = 1'b1;
               end
            end
         end
         tws_pkg::ST_WAIT: begin
            st_next.scl_oe = 1'b1;
            if (!st_reg.irq_flag) begin
               st_next.scl_oe  = 1'b0;
               st_next.bit_cnt = 4'h0;
               if (st_reg.status == tws_pkg::ST_OWN_DATA_NACK ||
                   st_reg.status == tws_pkg::ST_GC_DATA_NACK) begin
                  st_next.state      = tws_pkg::ST_IDLE;
                  st_next.start_pend = st_reg.start_request;
               end else begin
                  st_next.state = tws_pkg::ST_DATA;
               end
            end
         end
         tws_pkg::ST_DATA: begin
            if (scl_rise) begin
               st_next.shift   = {st_reg.shift[6:0], st_reg.sda_s2};
               st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            end else if (scl_fall && st_reg.bit_cnt == tws_pkg::BITS_PER_BYTE) begin
               // acknowledge follows the enable as it stands at the byte's end
               st_next.acked  = st_reg.ack_enable;
               st_next.sda_oe = st_reg.ack_enable;
               st_next.state  = tws_pkg::ST_DATA_ACK;
            end
         end
         tws_pkg::ST_DATA_ACK: begin
            if (scl_fall) begin
               st_next.sda_oe   = 1'b0;
               st_next.scl_oe   = 1'b1;
               st_next.irq_flag = 1'b1;
               st_next.state    = tws_pkg::ST_WAIT;
               // a byte caught while asleep is not kept
               if (!sleep_active) begin
                  st_next.data = st_reg.shift;
               end
               if (st_reg.gc_mode) begin
                  st_next.status = st_reg.acked ? tws_pkg::ST_GC_DATA_ACK
                                                : tws_pkg::ST_GC_DATA_NACK;
               end else begin
                  st_next.status = st_reg.acked ? tws_pkg::ST_OWN_DATA_ACK
                                                : tws_pkg::ST_OWN_DATA_NACK;
               end
            end
         end
         default: begin
            st_next.state = tws_pkg::ST_IDLE;
         end
      endcase

      // start and stop are seen in every state but the stretched wait,
      // where the held clock makes them impossible
      if (st_reg.state != tws_pkg::ST_WAIT && (start_cond || stop_cond)) begin
         st_next.sda_oe  = 1'b0;
         st_next.bit_cnt = 4'h0;
         st_next.state   = start_cond ? tws_pkg::ST_ADDR : tws_pkg::ST_IDLE;
         if (addressed) begin
            st_next.status   = tws_pkg::ST_STOP_ADDRESSED;
            st_next.irq_flag = 1'b1;
         end
      end

      if (st_reg.start_pend && !st_reg.busy) begin
         st_next.start_issue   = 1'b1;
         st_next.start_pend    = 1'b0;
         st_next.start_request = 1'b0;
      end
      if (!sleep_active) begin
         st_next.wake = 1'b0;
      end
      if (!st_reg.iface_enable) begin
         st_next.state  = tws_pkg::ST_IDLE;
         st_next.sda_oe = 1'b0;
         st_next.scl_oe = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg          <= '0;
         st_reg.state    <= tws_pkg::ST_IDLE;
         st_reg.own_addr <= tws_pkg::RST_OWN_ADDRESS;
         st_reg.status   <= tws_pkg::ST_NO_INFO;
         st_reg.data     <= tws_pkg::RST_BUS_DATA;
         st_reg.scl_s1   <= 1'b1;
         st_reg.scl_s2   <= 1'b1;
         st_reg.scl_s3   <= 1'b1;
         st_reg.sda_s1   <= 1'b1;
         st_reg.sda_s2   <= 1'b1;
         st_reg.sda_s3   <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_own_match;
      (st_reg.state == tws_pkg::ST_ADDR_ACK) && !st_reg.gc_mode
         |-> st_reg.shift[7:1] == st_reg.own_addr[7:1];
   endproperty
   a_own_match: assert property (p_own_match) else $error("ack for a foreign address");

   property p_gc_enable;
      (st_reg.state == tws_pkg::ST_ADDR_ACK) && st_reg.gc_mode
         |-> st_reg.own_addr[tws_pkg::BIT_GC_ENABLE]
             && st_reg.shift[7:1] == tws_pkg::GENERAL_CALL_ADDR;
   endproperty
   a_gc_enable: assert property (p_gc_enable) else $error("general call acked while off");

   property p_ack_needs_enable;
      (st_reg.state == tws_pkg::ST_ADDR) ##1 (st_reg.state == tws_pkg::ST_ADDR_ACK)
         |-> $past(st_reg.ack_enable) && !st_reg.shift[0];
   endproperty
   a_ack_needs_enable: assert property (p_ack_needs_enable) else $error("address acked wrongly");

   property p_addr_status;
      (st_reg.state == tws_pkg::ST_ADDR_ACK) && scl_fall
         |=> st_reg.irq_flag && st_reg.scl_oe && (st_reg.status == tws_pkg::ST_OWN_WRITE_ACK
             || st_reg.status == tws_pkg::ST_GCALL_ACK || st_reg.status == tws_pkg::ST_ARB_OWN_WRITE
             || st_reg.status == tws_pkg::ST_ARB_GCALL);
   endproperty
   a_addr_status: assert property (p_addr_status) else $error("no flag after address");

   property p_stretch;
      (st_reg.state == tws_pkg::ST_WAIT) && st_reg.irq_flag |=> st_reg.scl_oe;
   endproperty
   a_stretch: assert property (p_stretch) else $error("clock released while flag set");

   property p_nack_level;
      (st_reg.state == tws_pkg::ST_DATA_ACK) && !st_reg.acked |-> !st_reg.sda_oe;
   endproperty
   a_nack_level: assert property (p_nack_level) else $error("data line driven on nack");

   property p_data_status;
      (st_reg.state == tws_pkg::ST_DATA_ACK) && scl_fall && !st_reg.gc_mode
         |=> st_reg.status == (st_reg.acked ? tws_pkg::ST_OWN_DATA_ACK
                                            : tws_pkg::ST_OWN_DATA_NACK);
   endproperty
   a_data_status: assert property (p_data_status) else $error("wrong own data status");

   property p_gc_status;
      (st_reg.state == tws_pkg::ST_DATA_ACK) && scl_fall && st_reg.gc_mode
         |=> st_reg.status == (st_reg.acked ? tws_pkg::ST_GC_DATA_ACK
                                            : tws_pkg::ST_GC_DATA_NACK);
   endproperty
   a_gc_status: assert property (p_gc_status) else $error("wrong general call status");

   property p_nack_leave;
      (st_reg.state == tws_pkg::ST_WAIT) && !st_reg.irq_flag && st_reg.iface_enable
         && (st_reg.status == tws_pkg::ST_OWN_DATA_NACK
             || st_reg.status == tws_pkg::ST_GC_DATA_NACK)
         |=> (st_reg.state == tws_pkg::ST_IDLE) ##1 !st_reg.scl_oe;
   endproperty
   a_nack_leave: assert property (p_nack_leave) else $error("not back to idle after nack");

   c_own_byte: cover property (st_reg.status == 8'h60 ##[1:1000] st_reg.status == 8'h80);
   c_gc_byte: cover property (st_reg.status == 8'h70 ##[1:1000] st_reg.status == 8'h90);
   c_nack: cover property (st_reg.status == 8'h88 ##[1:1000] st_reg.state == tws_pkg::ST_IDLE);
   c_wake: cover property ($rose(st_reg.wake));

endmodule : tws_slave_receiver

// >>> verification/tb_top.sv
/*
   Self-checking bench of the two-wire slave receiver: APB tasks, a bus
   master model and frame sequences with expected status codes.
   Assumes the pull-ups of both bus lines are resolved here.
*/
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] A_CTL = tws_pkg::OFS_BUS_CONTROL;
   localparam logic [7:0] A_OWN = tws_pkg::OFS_OWN_ADDRESS;
   localparam logic [7:0] A_STA = tws_pkg::OFS_BUS_STATUS;
   localparam logic [7:0] A_DAT = tws_pkg::OFS_BUS_DATA;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, wake_req, start_issue;
   logic        sleep_active = 1'b0;
   logic        arb_lost = 1'b0;
   logic        m_scl, m_sda, scl_w, sda_w;
   int          failures = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   int          start_at = 0;

   always #12.5 pclk = ~pclk;
   assign scl_w = m_scl & (scl_oe ? scl_o : 1'b1);
   assign sda_w = m_sda & (sda_oe ? sda_o : 1'b1);

   tws_slave_receiver dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .sleep_active(sleep_active),
      .arb_lost(arb_lost), .wake_req(wake_req), .start_issue(start_issue));
   tws_bus_master bus_master (.scl_w(scl_w), .sda_w(sda_w), .scl_rel(m_scl), .sda_rel(m_sda));

   task automatic test_done();
      if (failures == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done

   // a hang anywhere ends the run as a failure
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (start_issue === 1'b1) start_at <= cycles;
      if (cycles == 30000) begin
         failures = failures + 1;
         test_done();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h00_0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic err;
      apb(1'b0, a, 8'h00, d, err);
   endtask : rd

   task automatic wait_flag();
      logic [31:0] d;
      int          n;
      n = 0;
      do begin
         rd(A_CTL, d);
         n++;
      end while (d[7] !== 1'b1 && n < 200);
      check(32'(d[7]), 32'h0000_0001);
   endtask : wait_flag

   task automatic chk_st(input logic [7:0] code);
      logic [31:0] d;
      rd(A_STA, d);
      check(d & 32'h0000_00F8, 32'(code));
   endtask : chk_st

   // release the stretched clock, then end the transfer with a stop
   task automatic end_frame();
      wr(A_CTL, 8'hC4);
      repeat (3) @(posedge pclk);
      check(32'(scl_oe), 32'h0000_0000);
      bus_master.stop_cond();
      wait_flag();
      chk_st(tws_pkg::ST_STOP_ADDRESSED);
      wr(A_CTL, 8'hC4);
   endtask : end_frame

   task automatic addr_frame(input logic [7:0] a, input logic ack_exp, input logic [7:0] code);
      logic        ack;
      logic [31:0] d;
      bus_master.start_cond();
      bus_master.send_byte(a, ack);
      check(32'(ack), 32'(ack_exp));
      if (ack_exp) begin
         wait_flag();
         check(32'(scl_oe), 32'h0000_0001);
         chk_st(code);
         end_frame();
      end else begin
         bus_master.stop_cond();
         rd(A_CTL, d);
         check(d & 32'h0000_0080, 32'h0000_0000);
      end
   endtask : addr_frame

   task automatic data_step(input logic [7:0] ctl, input logic [7:0] b, input logic ack_exp,
                            input logic [7:0] code);
      logic ack;
      wr(A_CTL, ctl);
      bus_master.send_byte(b, ack);
      check(32'(ack), 32'(ack_exp));
      wait_flag();
      chk_st(code);
   endtask : data_step

   initial begin
      logic [31:0] d;
      logic        e;
      logic        ack;
      int          mark;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_CTL, d);
      check(d, 32'h0000_0000);
      rd(A_OWN, d);
      check(d, 32'h0000_00FE);
      rd(A_STA, d);
      check(d, 32'h0000_00F8);
      rd(A_DAT, d);
      check(d, 32'h0000_00FF);
      apb(1'b0, 8'h10, 8'h00, d, e);
      check({d[30:0], e}, 32'h0000_0001);
      // data write with the flag down is refused and marks a collision
      wr(A_DAT, 8'h12);
      rd(A_DAT, d);
      check(d, 32'h0000_00FF);
      rd(A_CTL, d);
      check(d, 32'h0000_0008);
      wr(A_OWN, 8'hA5);
      rd(A_OWN, d);
      check(d, 32'h0000_00A5);
      // nonzero prescaler so every status compare relies on the mask
      wr(A_STA, 8'h03);
      rd(A_STA, d);
      check(d, 32'h0000_00FB);
      wr(A_CTL, 8'h44);
      addr_frame(8'hA4, 1'b1, tws_pkg::ST_OWN_WRITE_ACK);
      addr_frame(8'h00, 1'b1, tws_pkg::ST_GCALL_ACK);
      arb_lost <= 1'b1;
      addr_frame(8'hA4, 1'b1, tws_pkg::ST_ARB_OWN_WRITE);
      addr_frame(8'h00, 1'b1, tws_pkg::ST_ARB_GCALL);
      arb_lost <= 1'b0;
      addr_frame(8'hA6, 1'b0, 8'h00);
      addr_frame(8'hA5, 1'b0, 8'h00);
      wr(A_OWN, 8'hA4);
      addr_frame(8'h00, 1'b0, 8'h00);
      wr(A_OWN, 8'hA5);
      wr(A_CTL, 8'h04);
      addr_frame(8'hA4, 1'b0, 8'h00);
      wr(A_CTL, 8'h44);
      addr_frame(8'hA4, 1'b1, tws_pkg::ST_OWN_WRITE_ACK);
      bus_master.start_cond();
      bus_master.send_byte(8'hA4, ack);
      wait_flag();
      data_step(8'hC4, 8'h3C, 1'b1, tws_pkg::ST_OWN_DATA_ACK);
      rd(A_DAT, d);
      check(d, 32'h0000_003C);
      data_step(8'h84, 8'h5A, 1'b0, tws_pkg::ST_OWN_DATA_NACK);
      mark = cycles;
      wr(A_CTL, 8'hA4);
      bus_master.stop_cond();
      repeat (20) @(posedge pclk);
      check(32'(start_at > mark), 32'h0000_0001);
      wr(A_CTL, 8'h44);
      bus_master.start_cond();
      bus_master.send_byte(8'h00, ack);
      wait_flag();
      data_step(8'hC4, 8'h11, 1'b1, tws_pkg::ST_GC_DATA_ACK);
      data_step(8'h84, 8'h22, 1'b0, tws_pkg::ST_GC_DATA_NACK);
      wr(A_CTL, 8'hC4);
      bus_master.send_byte(8'hA4, ack);
      check(32'(ack), 32'h0000_0000);
      bus_master.stop_cond();
      addr_frame(8'hA4, 1'b1, tws_pkg::ST_OWN_WRITE_ACK);
      sleep_active <= 1'b1;
      bus_master.start_cond();
      bus_master.send_byte(8'hA4, ack);
      check(32'(ack), 32'h0000_0001);
      wait_flag();
      check(32'(wake_req), 32'h0000_0001);
      repeat (40) @(posedge pclk);
      check(32'(scl_w), 32'h0000_0000);
      sleep_active <= 1'b0;
      end_frame();
      check(32'(wake_req), 32'h0000_0000);
      test_done();
   end
endmodule : tb_top

// >>> verification/tws_bus_master.sv
/*
   Behavioural two-wire bus master transmitter for the slave receiver bench.
   Assumes open-drain wiring with pull-ups outside: both outputs are 1 while
   the line is released, and the wire is low if either party pulls it.
*/
`timescale 1ns/1ps
module tws_bus_master (
   input  wire logic scl_w,
   input  wire logic sda_w,
   output logic      scl_rel,
   output logic      sda_rel
);
   initial begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
   end

   // 200 ns bit period; a stretching slave only lengthens the low phase
   task automatic bit_io(input logic b, output logic seen);
      #40 sda_rel = b;
      #60 scl_rel = 1'b1;
      wait (scl_w === 1'b1);
      #60 seen = sda_w;
      #40 scl_rel = 1'b0;
   endtask : bit_io

   task automatic start_cond();
      #7 sda_rel = 1'b1;
      #50 scl_rel = 1'b1;
      wait (scl_w === 1'b1);
      #100 sda_rel = 1'b0;
      #100 scl_rel = 1'b0;
   endtask : start_cond

   task automatic stop_cond();
      #40 sda_rel = 1'b0;
      #60 scl_rel = 1'b1;
      wait (scl_w === 1'b1);
      #107 sda_rel = 1'b1;
      #100;
   endtask : stop_cond

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], seen);
      end
      bit_io(1'b1, seen);
      ack = ~seen;
   endtask : send_byte
endmodule : tws_bus_master
